// file: logic/static_memory_strobe_timing.sv
// Summary of operation
// RULE1 - 32-bit bus: address bits one, zero unused
// RULE2 - 16-bit bus: A1 on lane two pin
// RULE3 - byte access type picks selects or writes
// RULE4 - drive address at read start per width
// RULE5 - lane selects timed exactly like address
// RULE6 - lane write strobes share write timing
// RULE7 - address setup before read strobe falls
// RULE8 - read strobe low for pulse count
// RULE9 - chip select read waveform independent
// RULE10 - timings per chip select, whole cycles
// RULE11 - read holds derived from cycle count
// RULE12 - zero setup/hold keeps read strobes asserted
// RULE13 - software programs pulses at least one
// RULE14 - read selector alone picks sample point
// RULE15 - selector one samples at read rise
// RULE16 - selector zero samples at select rise
// RULE17 - address and data before write falls
// RULE18 - address, data held for write hold
// RULE19 - chip select write waveform own counts
// RULE20 - software programs cycle, not hold
// RULE21 - zero setup keeps write strobes asserted
// RULE22 - software gives setup or hold for latching
// RULE23 - write selector one: drive after strobe setup
// RULE24 - write selector zero: drive after select setup
// RULE25 - coded fields expand to cycle counts
// RULE26 - reset timings zero, one, three cycles
// RULE27 - idle: strobes high, drivers off
// RULE28 - counter runs from zero to cycle minus one
`timescale 1ns/10ps
`default_nettype none
module static_memory_strobe_timing
    import strobe_timing_pkg::*;
#(
    parameter int NUM_CS = 8,
    parameter int CS_W = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cfg_wr,
    input wire logic [CS_W-1:0] cfg_cs,
    input wire logic [31:0] cfg_setup_word,
    input wire logic [31:0] cfg_pulse_word,
    input wire logic [31:0] cfg_cycle_word,
    input wire logic [31:0] cfg_mode_word,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [CS_W-1:0] req_cs,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [3:0] req_be,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_data,
    output logic [NUM_CS-1:0] chip_select_strobe_n,
    output logic read_strobe_n,
    output logic write_or_lane0_write_pin,
    output logic lane0_or_addr0_pin,
    output logic lane1_shared_pin,
    output logic lane2_or_addr1_pin,
    output logic lane3_shared_pin,
    output logic [ADDR_W-1:2] mem_addr,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [DATA_W-1:0] data_in
);

    // per chip select configuration storage
    logic [31:0] setup_ff [NUM_CS];
    logic [31:0] pulse_ff [NUM_CS];
    logic [31:0] cycle_ff [NUM_CS];
    logic [NUM_CS-1:0] rmode_ff;
    logic [NUM_CS-1:0] wmode_ff;
    logic [NUM_CS-1:0] bat_ff;
    logic [1:0] dbw_ff [NUM_CS];

    // access state and latched timing of the running access
    state_t state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic wr_ff, nxt_wr;
    logic rmode_a_ff, nxt_rmode_a;
    logic bat_a_ff, nxt_bat_a;
    logic [1:0] dbw_a_ff, nxt_dbw_a;
    logic [CS_W-1:0] cs_a_ff, nxt_cs_a;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [3:0] be_ff, nxt_be;
    logic [DATA_W-1:0] wdata_ff, nxt_wdata;
    logic [CNT_W-1:0] cyc_m1_ff, nxt_cyc_m1;
    logic [CNT_W-1:0] ss_ff, nxt_ss;
    logic [CNT_W-1:0] se_ff, nxt_se;
    logic [CNT_W-1:0] cs_s_ff, nxt_cs_s;
    logic [CNT_W-1:0] cs_e_ff, nxt_cs_e;
    logic [CNT_W-1:0] oe_s_ff, nxt_oe_s;
    logic [CNT_W-1:0] samp_ff, nxt_samp;
    logic ready_ff;
    logic take, last;

    // parameters of the chip select being requested
    logic [31:0] sel_setup, sel_pulse, sel_cycle;
    logic [CNT_W-1:0] new_ss, new_sp, new_cs_s, new_cs_p, new_cyc;
    logic [CNT_W-1:0] new_we_s, new_cswr_s;

    // configuration writes, one word set per chip select [RULE10] [RULE26]
    for (genvar g = 0; g < NUM_CS; g++) begin : g_cfg
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                setup_ff[g] <= SETUP_RST;
                pulse_ff[g] <= PULSE_RST;
                cycle_ff[g] <= CYCLE_RST;
                rmode_ff[g] <= MODE_RST[MODE_READ_BIT];
                wmode_ff[g] <= MODE_RST[MODE_WRITE_BIT];
                bat_ff[g] <= MODE_RST[MODE_BAT_BIT];
                dbw_ff[g] <= MODE_RST[MODE_DBW_LSB +: 2];
            end else if (cfg_wr && cfg_cs == CS_W'(g)) begin
                setup_ff[g] <= cfg_setup_word;
                pulse_ff[g] <= cfg_pulse_word;
                cycle_ff[g] <= cfg_cycle_word;
                rmode_ff[g] <= cfg_mode_word[MODE_READ_BIT];
                wmode_ff[g] <= cfg_mode_word[MODE_WRITE_BIT];
                bat_ff[g] <= cfg_mode_word[MODE_BAT_BIT];
                dbw_ff[g] <= cfg_mode_word[MODE_DBW_LSB +: 2];
            end
        end
    end

    // expand the requested chip select's fields, read or write set [RULE9] [RULE19] [RULE25]
    always_comb begin
        sel_setup = setup_ff[req_cs];
        sel_pulse = pulse_ff[req_cs];
        sel_cycle = cycle_ff[req_cs];
        new_we_s = expand_setup(sel_setup[TW_WE_LSB +: SETUP_W]);
        new_cswr_s = expand_setup(sel_setup[TW_CS_WR_LSB +: SETUP_W]);
        if (req_write) begin
            new_ss = new_we_s;
            new_sp = expand_pulse(sel_pulse[TW_WE_LSB +: PULSE_W]);
            new_cs_s = new_cswr_s;
            new_cs_p = expand_pulse(sel_pulse[TW_CS_WR_LSB +: PULSE_W]);
            new_cyc = expand_cycle(sel_cycle[CYC_WR_LSB +: CYCLE_W]);
        end else begin
            new_ss = expand_setup(sel_setup[TW_RD_LSB +: SETUP_W]);
            new_sp = expand_pulse(sel_pulse[TW_RD_LSB +: PULSE_W]);
            new_cs_s = expand_setup(sel_setup[TW_CS_RD_LSB +: SETUP_W]);
            new_cs_p = expand_pulse(sel_pulse[TW_CS_RD_LSB +: PULSE_W]);
            new_cyc = expand_cycle(sel_cycle[CYC_RD_LSB +: CYCLE_W]);
        end
    end

    // a new access is taken when idle, or in the last cycle on the same chip select
    assign last = (cnt_ff == cyc_m1_ff);
    assign take = req_valid && ready_ff && (state_ff == ST_IDLE || req_cs == cs_a_ff);

    // sequencing and latching of the next access [RULE28]
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_wr = wr_ff;
        nxt_rmode_a = rmode_a_ff;
        nxt_bat_a = bat_a_ff;
        nxt_dbw_a = dbw_a_ff;
        nxt_cs_a = cs_a_ff;
        nxt_addr = addr_ff;
        nxt_be = be_ff;
        nxt_wdata = wdata_ff;
        nxt_cyc_m1 = cyc_m1_ff;
        nxt_ss = ss_ff;
        nxt_se = se_ff;
        nxt_cs_s = cs_s_ff;
        nxt_cs_e = cs_e_ff;
        nxt_oe_s = oe_s_ff;
        nxt_samp = samp_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_cnt = '0;
            end
            ST_ACCESS: begin
                if (last) begin
                    nxt_state = ST_IDLE;
                    nxt_cnt = '0;
                end else begin
                    nxt_cnt = cnt_ff + CNT_W'(1);
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_cnt = '0;
            end
        endcase
        if (take) begin
            nxt_state = ST_ACCESS;
            nxt_cnt = '0;
            nxt_wr = req_write;
            nxt_rmode_a = rmode_ff[req_cs];
            nxt_bat_a = bat_ff[req_cs];
            nxt_dbw_a = dbw_ff[req_cs];
            nxt_cs_a = req_cs;
            nxt_addr = req_addr;
            nxt_be = req_be;
            nxt_wdata = req_wdata;
            // hold is what is left of the cycle after setup and pulse [RULE11] [RULE18]
            nxt_cyc_m1 = (new_cyc == '0) ? '0 : new_cyc - CNT_W'(1);
            nxt_ss = new_ss;
            nxt_se = new_ss + new_sp;
            nxt_cs_s = new_cs_s;
            nxt_cs_e = new_cs_s + new_cs_p;
            // driver start set by the write selector [RULE23] [RULE24]
            nxt_oe_s = wmode_ff[req_cs] ? new_we_s : new_cswr_s;
            // sample point chosen by the read selector only [RULE14] [RULE13]
            nxt_samp = rmode_ff[req_cs] ? new_ss + new_sp - CNT_W'(1)
                                        : new_cs_s + new_cs_p - CNT_W'(1);
        end
    end

    // access state registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            wr_ff <= 1'b0;
            rmode_a_ff <= 1'b0;
            bat_a_ff <= BAT_SELECT;
            dbw_a_ff <= DBW_8;
            cs_a_ff <= '0;
            addr_ff <= '0;
            be_ff <= '0;
            wdata_ff <= '0;
            cyc_m1_ff <= '0;
            ss_ff <= '0;
            se_ff <= '0;
            cs_s_ff <= '0;
            cs_e_ff <= '0;
            oe_s_ff <= '0;
            samp_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            wr_ff <= nxt_wr;
            rmode_a_ff <= nxt_rmode_a;
            bat_a_ff <= nxt_bat_a;
            dbw_a_ff <= nxt_dbw_a;
            cs_a_ff <= nxt_cs_a;
            addr_ff <= nxt_addr;
            be_ff <= nxt_be;
            wdata_ff <= nxt_wdata;
            cyc_m1_ff <= nxt_cyc_m1;
            ss_ff <= nxt_ss;
            se_ff <= nxt_se;
            cs_s_ff <= nxt_cs_s;
            cs_e_ff <= nxt_cs_e;
            oe_s_ff <= nxt_oe_s;
            samp_ff <= nxt_samp;
        end
    end

    // ready for the next edge: idle, or about to be in the last cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ready_ff <= 1'b1;
        end else begin
            ready_ff <= (nxt_state == ST_IDLE) || (nxt_cnt == nxt_cyc_m1);
        end
    end
    assign req_ready = ready_ff;

    // strobe windows of the next cycle; zero setup/hold leaves no gap [RULE12] [RULE21]
    logic act_n, strb_on, cs_on, nxt_rd_n, nxt_oe;
    always_comb begin
        act_n = (nxt_state == ST_ACCESS);
        strb_on = act_n && nxt_cnt >= nxt_ss && nxt_cnt < nxt_se; // [RULE7] [RULE8] [RULE17]
        cs_on = act_n && nxt_cnt >= nxt_cs_s && nxt_cnt < nxt_cs_e; // [RULE9] [RULE19]
        nxt_rd_n = !(strb_on && !nxt_wr);
        nxt_oe = act_n && nxt_wr && nxt_cnt >= nxt_oe_s; // [RULE23] [RULE24]
    end

    // shared pin mapping by bus width and byte access type
    logic nxt_we_pin, nxt_l0, nxt_l1, nxt_l2, nxt_l3;
    logic [3:0] lane_sel, lane_wr;
    always_comb begin
        lane_sel = act_n ? ~nxt_be : 4'hf; // [RULE5]
        lane_wr = ~({4{strb_on && nxt_wr}} & nxt_be); // [RULE6]
        nxt_we_pin = !(strb_on && nxt_wr);
        nxt_l0 = 1'b1;
        nxt_l1 = 1'b1;
        nxt_l2 = 1'b1;
        nxt_l3 = 1'b1;
        case (nxt_dbw_a)
            DBW_8: begin
                // full byte address on the shared pins [RULE4]
                nxt_l0 = nxt_addr[0];
                nxt_l2 = nxt_addr[1];
            end
            DBW_16: begin
                nxt_l2 = nxt_addr[1]; // [RULE2]
                if (nxt_bat_a == BAT_WRITE) begin
                    nxt_we_pin = lane_wr[0]; // [RULE3]
                    nxt_l1 = lane_wr[1];
                end else begin
                    nxt_l0 = lane_sel[0]; // [RULE3]
                    nxt_l1 = lane_sel[1];
                end
            end
            default: begin
                // low two address bits not driven [RULE1]
                if (nxt_bat_a == BAT_WRITE) begin
                    nxt_we_pin = lane_wr[0]; // [RULE3]
                    nxt_l1 = lane_wr[1];
                    nxt_l2 = lane_wr[2];
                    nxt_l3 = lane_wr[3];
                end else begin
                    nxt_l0 = lane_sel[0]; // [RULE3]
                    nxt_l1 = lane_sel[1];
                    nxt_l2 = lane_sel[2];
                    nxt_l3 = lane_sel[3];
                end
            end
        endcase
    end

    // registered memory-side outputs, strobes high and data drivers off when idle [RULE27]
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chip_select_strobe_n <= '1;
            read_strobe_n <= 1'b1;
            write_or_lane0_write_pin <= 1'b1;
            lane0_or_addr0_pin <= 1'b1;
            lane1_shared_pin <= 1'b1;
            lane2_or_addr1_pin <= 1'b1;
            lane3_shared_pin <= 1'b1;
            mem_addr <= '0;
            data_out <= '0;
            data_oe <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_CS; i++) begin
                chip_select_strobe_n[i] <= !(cs_on && nxt_cs_a == CS_W'(i));
            end
            read_strobe_n <= nxt_rd_n;
            write_or_lane0_write_pin <= nxt_we_pin;
            lane0_or_addr0_pin <= nxt_l0;
            lane1_shared_pin <= nxt_l1;
            lane2_or_addr1_pin <= nxt_l2;
            lane3_shared_pin <= nxt_l3;
            mem_addr <= nxt_addr[ADDR_W-1:2]; // [RULE4]
            data_out <= nxt_wdata;
            data_oe <= nxt_oe;
        end
    end

    // read data capture on the edge that raises the controlling strobe [RULE15] [RULE16]
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else begin
            rd_valid <= 1'b0;
            if (state_ff == ST_ACCESS && !wr_ff && cnt_ff == samp_ff) begin
                rd_valid <= 1'b1;
                rd_data <= data_in;
            end
        end
    end

    // checks
    a_idle_inactive: assert property (@(posedge clk) disable iff (!nrst)
        state_ff == ST_IDLE |-> (&chip_select_strobe_n) && read_strobe_n && !data_oe
            && write_or_lane0_write_pin && lane3_shared_pin && lane1_shared_pin) // [RULE27]
        else $error("strobe or driver active while idle");

    a_read_fall_setup: assert property (@(posedge clk) disable iff (!nrst)
        $fell(read_strobe_n) |-> state_ff == ST_ACCESS && cnt_ff == ss_ff && !wr_ff) // [RULE7]
        else $error("read strobe fell away from its setup count");

    a_read_rise_pulse: assert property (@(posedge clk) disable iff (!nrst)
        $rose(read_strobe_n) && state_ff == ST_ACCESS && cnt_ff != '0
            |-> cnt_ff == se_ff) // [RULE8]
        else $error("read strobe low time differs from pulse count");

    a_sample_read: assert property (@(posedge clk) disable iff (!nrst)
        $rose(read_strobe_n) && $past(rmode_a_ff) && $past(state_ff == ST_ACCESS)
            |-> rd_valid) // [RULE15]
        else $error("read data not sampled at read strobe rise");

    a_sample_select: assert property (@(posedge clk) disable iff (!nrst)
        $rose(&chip_select_strobe_n) && $past(!rmode_a_ff && !wr_ff)
            && $past(state_ff == ST_ACCESS) |-> rd_valid) // [RULE16]
        else $error("read data not sampled at chip select rise");

    a_sample_point: assert property (@(posedge clk) disable iff (!nrst)
        rd_valid |-> $past(cnt_ff) == $past(samp_ff) && !$past(wr_ff)) // [RULE14]
        else $error("read data sampled at wrong count");

    a_write_fall_setup: assert property (@(posedge clk) disable iff (!nrst)
        $fell(write_or_lane0_write_pin) && dbw_a_ff != DBW_8 |-> cnt_ff == ss_ff && wr_ff
            ##1 !data_oe || data_out == $past(data_out)) // [RULE17]
        else $error("write strobe fell away from its setup count");

    a_oe_window: assert property (@(posedge clk) disable iff (!nrst)
        data_oe |-> wr_ff && state_ff == ST_ACCESS && cnt_ff >= oe_s_ff) // [RULE23]
        else $error("data drivers on outside the write window");

    a_addr_stable: assert property (@(posedge clk) disable iff (!nrst)
        state_ff == ST_ACCESS && cnt_ff != '0 |-> $stable(mem_addr) && $stable(data_out)) // [RULE18]
        else $error("address or data changed inside an access");

    a_cycle_bound: assert property (@(posedge clk) disable iff (!nrst)
        state_ff == ST_ACCESS |-> cnt_ff <= cyc_m1_ff) // [RULE28]
        else $error("cycle counter passed the cycle count");

endmodule : static_memory_strobe_timing
`default_nettype wire

// file: logic/strobe_timing_pkg.sv
`default_nettype none
package strobe_timing_pkg;

    // coded timing field widths and expanded counter width
    localparam int SETUP_W = 6;
    localparam int PULSE_W = 7;
    localparam int CYCLE_W = 9;
    localparam int CNT_W = 10;
    localparam int ADDR_W = 26;
    localparam int DATA_W = 32;

    // field positions inside the setup and pulse words
    localparam int TW_WE_LSB = 0;
    localparam int TW_CS_WR_LSB = 8;
    localparam int TW_RD_LSB = 16;
    localparam int TW_CS_RD_LSB = 24;

    // field positions inside the cycle word
    localparam int CYC_WR_LSB = 0;
    localparam int CYC_RD_LSB = 16;

    // field positions inside the mode word
    localparam int MODE_READ_BIT = 0;
    localparam int MODE_WRITE_BIT = 1;
    localparam int MODE_BAT_BIT = 8;
    localparam int MODE_DBW_LSB = 12;

    // reset values of the per chip select words
    localparam logic [31:0] SETUP_RST = 32'h00000000;
    localparam logic [31:0] PULSE_RST = 32'h01010101;
    localparam logic [31:0] CYCLE_RST = 32'h00030003;
    localparam logic [31:0] MODE_RST = 32'h00000000;

    // data bus width and byte access type codes
    localparam logic [1:0] DBW_8 = 2'h0;
    localparam logic [1:0] DBW_16 = 2'h1;
    localparam logic [1:0] DBW_32 = 2'h2;
    localparam logic BAT_SELECT = 1'b0;
    localparam logic BAT_WRITE = 1'b1;

    typedef enum logic {ST_IDLE = 1'b0, ST_ACCESS = 1'b1} state_t;

    // coded fields to effective cycle counts [RULE25]
    function automatic logic [CNT_W-1:0] expand_setup(input logic [SETUP_W-1:0] c);
        return {2'h0, c[5], 2'h0, c[4:0]};
    endfunction : expand_setup

    function automatic logic [CNT_W-1:0] expand_pulse(input logic [PULSE_W-1:0] c);
        return {1'h0, c[6], 2'h0, c[5:0]};
    endfunction : expand_pulse

    function automatic logic [CNT_W-1:0] expand_cycle(input logic [CYCLE_W-1:0] c);
        return {c[8:7], 1'h0, c[6:0]};
    endfunction : expand_cycle

endpackage : strobe_timing_pkg
`default_nettype wire

// file: tb/sram_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module sram_far_side
    import strobe_timing_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] cs_n,
    input wire logic rd_n,
    input wire logic we_pin,
    input wire logic [3:0] lane_pins,
    input wire logic [ADDR_W-1:2] addr,
    input wire logic [DATA_W-1:0] dout,
    input wire logic oe,
    input wire logic byte_access_type,
    output logic [DATA_W-1:0] din
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] last;
    logic sel;
    logic [3:0] wl;
    // selected and output enabled: drive word, else an inverted stale pattern
    assign sel = ~(&cs_n);
    assign din = (sel && !rd_n) ? mem[addr[5:2]] : ~last;
    // active low lane writes: own pins in byte write, strobe with select otherwise
    assign wl = byte_access_type ? {lane_pins[3:1], we_pin} : ({4{we_pin}} | lane_pins);
    // memory starts cleared
    initial begin
        last = '0;
        for (int i = 0; i < 16; i++) begin
            mem[i] = '0;
        end
    end
    // latch enabled lanes while selected and driven
    always @(posedge clk) begin
        if (sel && !rd_n) begin
            last <= mem[addr[5:2]];
        end
        for (int i = 0; i < 4; i++) begin
            if (sel && oe && !wl[i]) begin
                mem[addr[5:2]][8*i +: 8] <= dout[8*i +: 8];
            end
        end
    end
endmodule : sram_far_side
`default_nettype wire

// file: tb/static_memory_strobe_timing_bench.sv
`timescale 1ns/10ps
`default_nettype none
module static_memory_strobe_timing_bench import strobe_timing_pkg::*;;
    logic clk, nrst, cfg_wr, req_valid, req_write, req_ready, rd_valid, rd_n;
    logic [2:0] cfg_cs, req_cs;
    logic [31:0] s_w, p_w, c_w, m_w;
    logic [ADDR_W-1:0] req_addr;
    logic [3:0] req_be;
    logic [DATA_W-1:0] req_wdata, rd_data, data_out, data_in, rdat, dcap;
    logic [7:0] cs_n, lows;
    logic wpin, l0, l1, l2, l3, data_oe, byte_access_type, mon_on;
    logic [ADDR_W-1:2] mem_addr;
    logic [25:0] acap;
    int bad_count, comparisons, k, val_k, rdy_k;
    int fk [8];
    int ck [8];
    int lk [8];
    static_memory_strobe_timing DUT (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_cs(cfg_cs),
        .cfg_setup_word(s_w), .cfg_pulse_word(p_w), .cfg_cycle_word(c_w), .cfg_mode_word(m_w),
        .req_valid(req_valid), .req_write(req_write), .req_cs(req_cs), .req_addr(req_addr),
        .req_be(req_be), .req_wdata(req_wdata), .req_ready(req_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .chip_select_strobe_n(cs_n), .read_strobe_n(rd_n),
        .write_or_lane0_write_pin(wpin), .lane0_or_addr0_pin(l0), .lane1_shared_pin(l1),
        .lane2_or_addr1_pin(l2), .lane3_shared_pin(l3), .mem_addr(mem_addr),
        .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
    sram_far_side mem_model (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .we_pin(wpin),
        .lane_pins({l3, l2, l1, l0}), .addr(mem_addr), .dout(data_out), .oe(data_oe),
        .byte_access_type(byte_access_type), .din(data_in));
    // free running clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // per access trace: first active cycle, active count, last active cycle of each pin, data_oe active high, the others low
    always @(negedge clk) begin
        if (mon_on) begin
            lows = {data_oe === 1'b1, l3 === 1'b0, l2 === 1'b0, l1 === 1'b0, l0 === 1'b0,
                    wpin === 1'b0, cs_n === ~(8'h1 << req_cs), rd_n === 1'b0};
            for (int i = 0; i < 8; i++) begin
                if (lows[i]) begin
                    if (ck[i] == 0) fk[i] = k;
                    ck[i]++;
                    lk[i] = k;
                end
            end
            if (k == 0) acap = {mem_addr, l2, l0};
            if (data_oe === 1'b1) dcap = data_out;
            if (rd_valid === 1'b1 && val_k < 0) begin
                val_k = k;
                rdat = rd_data;
            end
            if (req_ready === 1'b1 && rdy_k < 0) rdy_k = k;
            k++;
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic chk_cnt(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk_cnt
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk_val
    task automatic tim(input int i, input int first, input int cnt);
        chk_cnt(fk[i], first);
        chk_cnt(ck[i], cnt);
    endtask : tim
    task automatic idle();
        chk_val({18'h0, cs_n, rd_n, wpin, l1, l3, data_oe, req_ready}, 32'h3ffd);
    endtask : idle
    function automatic logic [31:0] mk(input int we, input int csw, input int rd, input int csr);
        return (32'(we) << TW_WE_LSB) | (32'(csw) << TW_CS_WR_LSB) | (32'(rd) << TW_RD_LSB)
            | (32'(csr) << TW_CS_RD_LSB);
    endfunction : mk
    function automatic logic [31:0] md(input logic r, input logic w, input logic b,
                                       input logic [1:0] dbw);
        return (32'(r) << MODE_READ_BIT) | (32'(w) << MODE_WRITE_BIT) | (32'(b) << MODE_BAT_BIT)
            | (32'(dbw) << MODE_DBW_LSB);
    endfunction : md
    task automatic cfg(input logic [2:0] cs, input logic [31:0] s, input logic [31:0] p,
                       input int wc, input int rc, input logic [31:0] m);
        @(negedge clk);
        cfg_cs = cs;
        s_w = s;
        p_w = p;
        c_w = (32'(wc) << CYC_WR_LSB) | (32'(rc) << CYC_RD_LSB);
        m_w = m;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask : cfg
    // issue reps requests back to back, then trace n cycles from the first take
    task automatic go(input logic w, input logic [2:0] cs, input logic [25:0] a,
                      input logic [31:0] d, input int reps, input int n);
        int t;
        int g;
        logic rdy;
        t = 0;
        g = 0;
        @(negedge clk);
        req_write = w;
        req_cs = cs;
        req_addr = a;
        req_be = (a == 26'h14) ? 4'h5 : 4'hf;
        req_wdata = d;
        req_valid = 1'b1;
        while (t < reps && g < 50) begin
            rdy = req_ready;
            @(posedge clk);
            if (rdy === 1'b1) begin
                t++;
                if (t == 1) begin
                    for (int i = 0; i < 8; i++) begin
                        fk[i] = -1;
                        ck[i] = 0;
                        lk[i] = -1;
                    end
                    k = 0;
                    val_k = -1;
                    rdy_k = -1;
                    mon_on = 1'b1;
                end
            end
            @(negedge clk);
            g++;
        end
        req_valid = 1'b0;
        while (k < n && g < 2000) begin
            @(negedge clk);
            g++;
        end
        if (g >= 2000 || t < reps) begin
            chk_cnt((g < 2000) ? t : -1, reps);
            summarize();
        end
        idle();
        @(posedge clk);
        mon_on = 1'b0;
    endtask : go
    initial begin
        {nrst, cfg_wr, req_valid, req_write, byte_access_type, mon_on} = '0;
        {cfg_cs, req_cs, req_be, s_w, p_w, c_w, m_w, req_addr, req_wdata} = '0;
        bad_count = 0;
        comparisons = 0;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        idle();
        go(1'b0, 3'h0, 26'h7, 32'h0, 1, 5);
        tim(0, 0, 1);
        tim(1, 0, 1);
        chk_cnt(val_k, 1);
        chk_cnt(rdy_k, 2);
        chk_val(32'(acap), 32'h7);
        $display("test defaults done");
        cfg(3'h1, mk(2, 0, 1, 0), mk(2, 5, 2, 4), 6, 6, md(1, 1, BAT_SELECT, DBW_32));
        go(1'b1, 3'h1, 26'h10, 32'h1234abcd, 1, 8);
        tim(2, 2, 2);
        tim(1, 0, 5);
        tim(7, 2, 4);
        tim(3, 0, 6);
        tim(5, 0, 6);
        chk_val(dcap, 32'h1234abcd);
        chk_val(32'(acap), 32'h10);
        chk_cnt(rdy_k, 5);
        go(1'b0, 3'h1, 26'h10, 32'h0, 1, 8);
        tim(0, 1, 2);
        tim(1, 0, 4);
        chk_cnt(val_k, 3);
        chk_val(rdat, 32'h1234abcd);
        $display("test strobe control done");
        byte_access_type = 1'b1;
        cfg(3'h2, mk(0, 1, 0, 0), mk(3, 2, 4, 2), 5, 5, md(0, 0, BAT_WRITE, DBW_32));
        go(1'b1, 3'h2, 26'h14, 32'hcafe5a5a, 1, 7);
        tim(2, 0, 3);
        tim(5, 0, 3);
        chk_cnt(ck[4] + ck[6], 0);
        tim(1, 1, 2);
        tim(7, 1, 4);
        chk_cnt(rdy_k, 4);
        go(1'b0, 3'h2, 26'h14, 32'h0, 1, 7);
        chk_cnt(val_k, 2);
        chk_val(rdat, 32'h00fe005a);
        $display("test select control done");
        byte_access_type = 1'b0;
        cfg(3'h3, 32'h0, mk(3, 3, 3, 3), 3, 3, md(0, 0, BAT_SELECT, DBW_32));
        go(1'b0, 3'h3, 26'h10, 32'h0, 2, 9);
        tim(0, 0, 6);
        chk_cnt(lk[0], 5);
        tim(1, 0, 6);
        chk_cnt(lk[1], 5);
        go(1'b1, 3'h3, 26'h10, 32'h1234abcd, 2, 9);
        tim(2, 0, 6);
        chk_cnt(lk[2], 5);
        tim(1, 0, 6);
        $display("test back to back done");
        cfg(3'h4, mk(0, 0, 33, 0), mk(1, 1, 65, 1), 3, 385, md(1, 0, BAT_SELECT, DBW_32));
        go(1'b0, 3'h4, 26'h10, 32'h0, 1, 772);
        tim(0, 128 + 1, 256 + 1);
        chk_cnt(val_k, 128 + 1 + 256 + 1);
        chk_cnt(rdy_k, 3 * 256 + 1 - 1);
        go(1'b0, 3'h0, 26'h7, 32'h0, 1, 5);
        tim(0, 0, 1);
        chk_cnt(rdy_k, 2);
        $display("test coded fields done");
        cfg(3'h5, 32'h0, 32'h01010101, 3, 3, md(0, 0, BAT_SELECT, DBW_16));
        go(1'b0, 3'h5, 26'h7, 32'h0, 1, 5);
        chk_val(32'(acap), 32'h6);
        tim(4, 0, 3);
        chk_cnt(ck[6], 0);
        $display("test half width done");
        summarize();
    end
endmodule : static_memory_strobe_timing_bench
`default_nettype wire
